/* rtl/atp_regs.svh */
`ifndef ATP_REGS_SVH
`define ATP_REGS_SVH
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define ATP_OFS_CTRL0 8'h00
`define ATP_OFS_CTRL1 8'h04
`define ATP_OFS_CNT 8'h08
`define ATP_OFS_CMPA 8'h0C
`define ATP_OFS_CMPB 8'h10
`define ATP_OFS_PER 8'h14
`define ATP_OFS_FLAGS 8'h18
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ATP_C0_RUN 0
`define ATP_C0_AUDIO 1
`define ATP_C1_MODE_HI 7
`define ATP_C1_MODE_LO 6
`define ATP_C1_ACT_HI 5
`define ATP_C1_ACT_LO 4
`define ATP_C1_INIT 3
`define ATP_C1_INV 2
`define ATP_C1_SWAP 1
`define ATP_C1_CLR 0
`define ATP_FL_A 0
`define ATP_FL_P 1
`define ATP_FL_B 2
// ---------------------------------------------------------------
// Reset values and counts
// ---------------------------------------------------------------
`define ATP_RST_CTRL 8'h00
`define ATP_CNT_MAX 10'h3FF
`define ATP_PRESCALE 1
`endif

/* rtl/atp_pkg.sv */
package atp_pkg;
  typedef enum logic [1:0] {
    ATP_MODE_CMP = 2'b00,
    ATP_MODE_UNDEF = 2'b01,
    ATP_MODE_PWM = 2'b10,
    ATP_MODE_TMR = 2'b11
  } atp_mode_t;

  typedef struct packed {
    logic timer_out_pin;
    logic timer_out_pin_inv;
    logic audio_out_one;
    logic audio_out_two;
  } atp_pins_t;
endpackage

/* rtl/atp_timer.sv */
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`include "atp_regs.svh"

module atp_timer import atp_pkg::*; #(
  parameter int CNT_W = 10,
  parameter int PRESCALE = `ATP_PRESCALE
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Pins
  output atp_pins_t pins_out
);
  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  logic [7:0] timer_ctrl_reg_zero;
  logic [7:0] timer_ctrl_reg_one;
  logic [CNT_W-1:0] compare_a_value, compare_b_value;
  logic [7:0] period_compare_value;
  logic [CNT_W-1:0] act_a_reg, act_b_reg;
  logic [7:0] act_p_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic cmp_a_flag, period_match_flag, cmp_b_flag;
  logic run_d_reg;
  logic [7:0] pre_reg;
  logic tick;
  atp_pins_t pins_reg;

  wire logic counter_run_bit = timer_ctrl_reg_zero[`ATP_C0_RUN];
  wire logic audio_pwm_select = timer_ctrl_reg_zero[`ATP_C0_AUDIO];
  wire atp_mode_t mode = atp_mode_t'({timer_ctrl_reg_one[`ATP_C1_MODE_HI],
                                      timer_ctrl_reg_one[`ATP_C1_MODE_LO]});
  wire logic [1:0] pin_act = {timer_ctrl_reg_one[`ATP_C1_ACT_HI],
                              timer_ctrl_reg_one[`ATP_C1_ACT_LO]};
  wire logic out_initial_level = timer_ctrl_reg_one[`ATP_C1_INIT];
  wire logic out_invert_bit = timer_ctrl_reg_one[`ATP_C1_INV];
  wire logic counter_clear_sel = timer_ctrl_reg_one[`ATP_C1_CLR];
  wire logic is_pwm = (mode == ATP_MODE_PWM);
  wire logic is_audio = is_pwm && audio_pwm_select;
  // Swap reads as zero in audio mode
  wire logic period_duty_swap = timer_ctrl_reg_one[`ATP_C1_SWAP] && !is_audio;

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic [7:0] aw_reg;
  logic [31:0] wd_reg;
  logic aw_ok_reg, w_ok_reg;
  wire logic wr_go = aw_ok_reg && w_ok_reg && !s_axi_bvalid_out;
  wire logic clr_flag_wr = wr_go && aw_reg == `ATP_OFS_FLAGS;

  function automatic logic known(input logic [7:0] a);
    return a == `ATP_OFS_CTRL0 || a == `ATP_OFS_CTRL1 || a == `ATP_OFS_CNT ||
           a == `ATP_OFS_CMPA || a == `ATP_OFS_CMPB || a == `ATP_OFS_PER ||
           a == `ATP_OFS_FLAGS;
  endfunction

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      aw_ok_reg <= 1'b0;
      w_ok_reg <= 1'b0;
      aw_reg <= 8'h00;
      wd_reg <= 32'h0000_0000;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= 2'h0;
    end else begin
      s_axi_awready_out <= !aw_ok_reg && !s_axi_awready_out && s_axi_awvalid_in;
      s_axi_wready_out <= !w_ok_reg && !s_axi_wready_out && s_axi_wvalid_in;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_ok_reg <= 1'b1;
        aw_reg <= {s_axi_awaddr_in[7:2], 2'b00};
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_ok_reg <= 1'b1;
        wd_reg <= s_axi_wstrb_in[0] ? s_axi_wdata_in : 32'h0000_0000;
      end
      if (wr_go) begin
        aw_ok_reg <= 1'b0;
        w_ok_reg <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= known(aw_reg) ? 2'h0 : 2'h2;
      end else if (s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= 2'h0;
    end else begin
      s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out && s_axi_arvalid_in;
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rresp_out <= known({s_axi_araddr_in[7:2], 2'b00}) ? 2'h0 : 2'h2;
        unique case ({s_axi_araddr_in[7:2], 2'b00})
          `ATP_OFS_CTRL0: s_axi_rdata_out <= {24'h000000, timer_ctrl_reg_zero};
          `ATP_OFS_CTRL1: s_axi_rdata_out <= {24'h000000, timer_ctrl_reg_one[7:2],
                                              period_duty_swap, counter_clear_sel};
          `ATP_OFS_CNT: s_axi_rdata_out <= 32'(cnt_reg);
          `ATP_OFS_CMPA: s_axi_rdata_out <= 32'(compare_a_value);
          `ATP_OFS_CMPB: s_axi_rdata_out <= 32'(compare_b_value);
          `ATP_OFS_PER: s_axi_rdata_out <= {24'h000000, period_compare_value};
          `ATP_OFS_FLAGS: s_axi_rdata_out <= {29'h00000000, cmp_b_flag,
                                              period_match_flag, cmp_a_flag};
          default: s_axi_rdata_out <= 32'h0000_0000;
        endcase
      end else if (s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      timer_ctrl_reg_zero <= `ATP_RST_CTRL;
      timer_ctrl_reg_one <= `ATP_RST_CTRL;
      compare_a_value <= '0;
      compare_b_value <= '0;
      period_compare_value <= 8'h00;
    end else if (wr_go) begin
      unique case (aw_reg)
        `ATP_OFS_CTRL0: timer_ctrl_reg_zero <= wd_reg[7:0];
        `ATP_OFS_CTRL1: timer_ctrl_reg_one <= wd_reg[7:0];
        `ATP_OFS_CMPA: compare_a_value <= wd_reg[CNT_W-1:0];
        `ATP_OFS_CMPB: compare_b_value <= wd_reg[CNT_W-1:0];
        `ATP_OFS_PER: period_compare_value <= wd_reg[7:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Counter and comparators
  // ---------------------------------------------------------------
  // Timer clock enable from a prescaler; a shorter count speeds sims
  always_ff @(posedge clk_in) begin
    if (srst_in || !counter_run_bit || pre_reg == 8'(PRESCALE - 1)) begin
      pre_reg <= 8'h00;
    end else begin
      pre_reg <= pre_reg + 8'h01;
    end
  end
  assign tick = counter_run_bit && pre_reg == 8'(PRESCALE - 1);

  // Active compare values: shadowed only in audio mode
  wire logic [CNT_W-1:0] use_a = is_audio ? act_a_reg : compare_a_value;
  wire logic [CNT_W-1:0] use_b = is_audio ? act_b_reg : compare_b_value;
  wire logic [7:0] use_p = is_audio ? act_p_reg : period_compare_value;
  wire logic overflow = cnt_reg == `ATP_CNT_MAX;
  // Period compare sees only the top eight counter bits, so a zero value
  // means a full 1024-clock wrap
  wire logic [CNT_W-1:0] p_end = (use_p == 8'h00) ? `ATP_CNT_MAX
                                 : {use_p, 2'b00} - 10'h001;
  wire logic match_p = tick && cnt_reg == p_end;
  wire logic match_a = tick && use_a != '0 && cnt_reg == use_a - 10'h001;
  wire logic match_b = tick && use_b != '0 && cnt_reg == use_b - 10'h001;
  wire logic clr_on_a = is_pwm ? (period_duty_swap && !is_audio)
                               : counter_clear_sel;
  wire logic cnt_clear = clr_on_a ? (match_a || (tick && overflow))
                                  : match_p;

  always_ff @(posedge clk_in) begin
    if (srst_in || !counter_run_bit) begin
      cnt_reg <= '0;
    end else if (cnt_clear) begin
      cnt_reg <= '0;
    end else if (tick) begin
      cnt_reg <= cnt_reg + 10'h001;
    end
  end

  // Shadows load at the end of a period, with the period flag
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      act_a_reg <= '0;
      act_b_reg <= '0;
      act_p_reg <= 8'h00;
    end else if (!is_audio || !counter_run_bit || match_p) begin
      act_a_reg <= compare_a_value;
      act_b_reg <= compare_b_value;
      act_p_reg <= period_compare_value;
    end
  end

  // ---------------------------------------------------------------
  // Flags: a new match beats a software clear
  // ---------------------------------------------------------------
  wire logic set_a = match_a;
  wire logic set_p = match_p && !(clr_on_a && !is_pwm);
  wire logic set_b = match_b && is_audio;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cmp_a_flag <= 1'b0;
      period_match_flag <= 1'b0;
      cmp_b_flag <= 1'b0;
    end else begin
      cmp_a_flag <= set_a || (cmp_a_flag && !(clr_flag_wr && wd_reg[`ATP_FL_A]));
      period_match_flag <= set_p ||
                           (period_match_flag && !(clr_flag_wr && wd_reg[`ATP_FL_P]));
      cmp_b_flag <= set_b || (cmp_b_flag && !(clr_flag_wr && wd_reg[`ATP_FL_B]));
    end
  end

  // ---------------------------------------------------------------
  // Output pins
  // ---------------------------------------------------------------
  logic cmp_lvl_reg;
  always_ff @(posedge clk_in) begin
    run_d_reg <= !srst_in && counter_run_bit;
  end
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cmp_lvl_reg <= 1'b0;
    end else if (counter_run_bit && !run_d_reg) begin
      cmp_lvl_reg <= out_initial_level;
    end else if (set_a && mode == ATP_MODE_CMP) begin
      unique case (pin_act)
        2'b00: cmp_lvl_reg <= cmp_lvl_reg;
        2'b01: cmp_lvl_reg <= 1'b0;
        2'b10: cmp_lvl_reg <= 1'b1;
        2'b11: cmp_lvl_reg <= !cmp_lvl_reg;
      endcase
    end
  end

  // Duty window: active while the count is below the duty value
  function automatic logic pwm_lvl(input logic on);
    logic act;
    act = (pin_act == 2'b01) || (pin_act == 2'b10 && on);
    return (out_initial_level ? act : !act) ^ out_invert_bit;
  endfunction
  wire logic [CNT_W-1:0] duty_p = (use_p == 8'h00) ? 10'h000 : {use_p, 2'b00};
  wire logic on_n = period_duty_swap ? (use_p == 8'h00 || cnt_reg < duty_p)
                                     : (cnt_reg < use_a);
  wire logic cmp_pin = cmp_lvl_reg ^ out_invert_bit;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pins_reg <= '0;
    end else begin
      pins_reg <= '0;
      if (mode == ATP_MODE_CMP) begin
        pins_reg.timer_out_pin <= cmp_pin;
        pins_reg.timer_out_pin_inv <= !cmp_pin;
      end else if (is_audio) begin
        pins_reg.audio_out_one <= pwm_lvl(cnt_reg < use_a);
        pins_reg.audio_out_two <= pwm_lvl(cnt_reg < use_b);
      end else if (is_pwm) begin
        pins_reg.timer_out_pin <= pwm_lvl(on_n);
        pins_reg.timer_out_pin_inv <= !pwm_lvl(on_n);
      end
    end
  end
  assign pins_out = pins_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_cnt_clears: assert property (@(posedge clk_in) disable iff (srst_in)
    cnt_clear && counter_run_bit |=> cnt_reg == '0)
    else $error("counter not cleared after clear event");
  a_flag_sticky: assert property (@(posedge clk_in) disable iff (srst_in)
    cmp_a_flag && !clr_flag_wr |=> cmp_a_flag)
    else $error("compare A flag dropped without clear");
  a_set_wins: assert property (@(posedge clk_in) disable iff (srst_in)
    set_p |=> period_match_flag)
    else $error("period flag lost");
  a_no_pflag_clra: assert property (@(posedge clk_in) disable iff (srst_in)
    mode == ATP_MODE_CMP && counter_clear_sel && !period_match_flag
      && !$past(period_match_flag) |=> !period_match_flag || $past(!counter_clear_sel))
    else $error("period flag raised with clear on A");
  a_init_level: assert property (@(posedge clk_in) disable iff (srst_in)
    counter_run_bit && !run_d_reg |=> cmp_lvl_reg == $past(out_initial_level))
    else $error("initial level not loaded");
  a_tmr_quiet: assert property (@(posedge clk_in) disable iff (srst_in)
    mode == ATP_MODE_TMR |=> ##1 (pins_out == '0 || $past(mode) != ATP_MODE_TMR))
    else $error("timer mode drove a pin");
  a_zero_a_nomatch: assert property (@(posedge clk_in) disable iff (srst_in)
    use_a == '0 |-> !match_a)
    else $error("compare A matched at zero");
  a_audio_shadow: assert property (@(posedge clk_in) disable iff (srst_in)
    is_audio && counter_run_bit && !match_p && $stable(is_audio) |=> $stable(act_a_reg))
    else $error("active compare A changed mid period");
  a_cmp_pin_hold: assert property (@(posedge clk_in) disable iff (srst_in)
    mode == ATP_MODE_CMP && !set_a && !(counter_run_bit && !run_d_reg) |=> $stable(cmp_lvl_reg))
    else $error("compare pin level moved without compare A match");
  a_b_flag_audio: assert property (@(posedge clk_in) disable iff (srst_in)
    !is_audio && !cmp_b_flag |=> !cmp_b_flag)
    else $error("compare B flag raised outside audio mode");
  a_run_low_cnt: assert property (@(posedge clk_in) disable iff (srst_in)
    !counter_run_bit |=> cnt_reg == '0)
    else $error("counter not held at zero while stopped");
endmodule

/* tb/atp_pin_load.sv */
module atp_pin_load import atp_pkg::*; (
  // Clock and gate
  input wire logic clk_in,
  input wire logic gate_in,
  // Pins seen by the loads
  input wire atp_pins_t pins_in,
  // High-time totals over the gated window
  output logic [15:0] high_p_out,
  output logic [15:0] high_pb_out,
  output logic [15:0] high_one_out,
  output logic [15:0] high_two_out
);
  // ---------------------------------------------------------------
  // Loads integrate high time; a gated window avoids phase guessing
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!gate_in) begin
      high_p_out <= 16'h0000;
      high_pb_out <= 16'h0000;
      high_one_out <= 16'h0000;
      high_two_out <= 16'h0000;
    end else begin
      high_p_out <= high_p_out + 16'(pins_in.timer_out_pin);
      high_pb_out <= high_pb_out + 16'(pins_in.timer_out_pin_inv);
      high_one_out <= high_one_out + 16'(pins_in.audio_out_one);
      high_two_out <= high_two_out + 16'(pins_in.audio_out_two);
    end
  end
endmodule

/* tb/testbench.sv */
`include "atp_regs.svh"
module testbench import atp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  atp_pins_t pins;
  logic gate = 1'b0;
  logic [15:0] hp, hpb, h1, h2;
  logic [31:0] rd;
  logic [1:0] rs;
  logic [1:0] bs;
  int bad_count = 0;
  int checked = 0;
  atp_timer u_dut (.clk_in(clk_in), .srst_in(srst_in), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .pins_out(pins));
  atp_pin_load u_load (.clk_in(clk_in), .gate_in(gate), .pins_in(pins), .high_p_out(hp),
    .high_pb_out(hpb), .high_one_out(h1), .high_two_out(h2));
  initial begin
    forever #50 clk_in = ~clk_in;
  end
  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (e !== g) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick_guard(inout int n);
    n++;
    if (n > 50) begin
      bad_count++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk_in);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        bs = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
      tick_guard(n);
    end
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk_in);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
      tick_guard(n);
    end
  endtask
  // Stop first so mode and pin action never change while counting
  task automatic setup(input logic [7:0] c1, input logic [9:0] a, input logic [9:0] b,
    input logic [7:0] p, input logic [1:0] c0);
    wr(`ATP_OFS_CTRL0, 32'h0);
    wr(`ATP_OFS_FLAGS, 32'h7);
    wr(`ATP_OFS_CMPA, {22'h0, a});
    wr(`ATP_OFS_CMPB, {22'h0, b});
    wr(`ATP_OFS_PER, {24'h0, p});
    wr(`ATP_OFS_CTRL1, {24'h0, c1});
    wr(`ATP_OFS_CTRL0, {30'h0, c0});
    repeat (40) @(posedge clk_in);
  endtask
  task automatic meas(input int n);
    @(posedge clk_in);
    gate <= 1'b1;
    repeat (n) @(posedge clk_in);
    gate <= 1'b0;
    #1;
  endtask
  task automatic flags(input logic [31:0] e);
    rdr(`ATP_OFS_FLAGS, rd, rs);
    chk("flags", e, rd);
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_in);
    chk("pins_rst", 32'h0, {28'h0, pins});
    srst_in <= 1'b0;
    rdr(`ATP_OFS_CTRL1, rd, rs);
    chk("ctrl1_rst", 32'h0, rd);
    rdr(8'h1C, rd, rs);
    chk("unmapped_resp", 32'h2, {30'h0, rs});
    wr(8'h1C, 32'h5);
    chk("unmapped_bresp", 32'h2, {30'h0, bs});
    // Toggle on A match each 8-cycle period: square wave of 16
    setup(8'h30, 10'h003, 10'h000, 8'h02, 2'b01);
    meas(80);
    chk("toggle_high", 32'd40, {16'h0, hp});
    chk("toggle_inv", 32'd40, {16'h0, hpb});
    flags(32'h3);
    wr(`ATP_OFS_CTRL0, 32'h0);
    wr(`ATP_OFS_FLAGS, 32'h3);
    flags(32'h0);
    // Clear on A with period value below A; action keeps initial high
    setup(8'h09, 10'h005, 10'h000, 8'h01, 2'b01);
    meas(50);
    chk("init_high", 32'd50, {16'h0, hp});
    flags(32'h1);
    rdr(`ATP_OFS_CNT, rd, rs);
    chk("cnt_below_a", 32'h1, {31'h0, rd < 32'd5});
    // Drive low on A match from an initial high level
    setup(8'h18, 10'h003, 10'h000, 8'h02, 2'b01);
    meas(80);
    chk("cmp_low", 32'h0, {16'h0, hp});
    setup(8'hF9, 10'h005, 10'h000, 8'h01, 2'b01);
    meas(50);
    chk("tmr_pins", 32'h0, {hp, hpb | h1 | h2});
    flags(32'h1);
    setup(8'h21, 10'h000, 10'h000, 8'h00, 2'b01);
    meas(1100);
    chk("a_zero_pin", 32'h0, {16'h0, hp});
    flags(32'h0);
    // Normal PWM, clear select set but ignored
    setup(8'hA9, 10'h004, 10'h000, 8'h04, 2'b01);
    meas(160);
    chk("pwm_true", 32'd40, {16'h0, hp});
    chk("pwm_inv_pin", 32'd120, {16'h0, hpb});
    flags(32'h3);
    setup(8'hAA, 10'd20, 10'h000, 8'h02, 2'b01);
    meas(200);
    chk("pwm_swap", 32'd80, {16'h0, hp});
    setup(8'hAC, 10'h004, 10'h000, 8'h04, 2'b01);
    meas(160);
    chk("pwm_invert", 32'd120, {16'h0, hp});
    setup(8'h98, 10'h004, 10'h000, 8'h04, 2'b01);
    meas(160);
    chk("pwm_forced", 32'd160, {16'h0, hp});
    flags(32'h3);
    setup(8'hB8, 10'h004, 10'h000, 8'h04, 2'b01);
    meas(160);
    chk("pwm_act_undef", 32'h0, {16'h0, hp});
    // Audio PWM with swap written high; duty below period throughout
    setup(8'hAA, 10'h004, 10'h00C, 8'h04, 2'b11);
    rdr(`ATP_OFS_CTRL1, rd, rs);
    chk("swap_held", 32'hA8, rd);
    meas(160);
    chk("audio_one", 32'd40, {16'h0, h1});
    chk("audio_two", 32'd120, {16'h0, h2});
    flags(32'h7);
    wr(`ATP_OFS_CMPA, 32'h8);
    chk("bresp_ok", 32'h0, {30'h0, bs});
    repeat (40) @(posedge clk_in);
    meas(160);
    chk("audio_reload", 32'd80, {16'h0, h1});
    stop_test();
  end
endmodule
